/* logic/pdm_params.sv */
// motion parameter set of a positioning drive with link-loss supervision
// Summary of operation
// RULE1: an approach covers at least the loop length in steps, and a length of zero turns the loop off.
// RULE2: loop side 0 approaches with a forward loop and 1 with a backward loop.
// RULE3: the following error flag is set once commanded and actual position differ by more than the limit.
// RULE4: loop side and jog step count may be changed only while the drive stands still.
// RULE5: a brief button press or jog command moves the drive by exactly the jog step count.
// RULE6: the brake release drive moves by the brake release step count.
// RULE7: on link loss, reaction 1 cancels the drive, 2 drives to the safe position, 0 is reserved.
// RULE8: link loss is detected only while the communication timeout is above zero.
// RULE9: with the safe reaction the drive moves to the stored signed safe position.
// RULE10: position drives stay at or below the position drive speed limit.
// RULE11: manual drives stay at or below the manual drive speed limit.
// RULE12: a drive is cancelled when its speed drops below the abort percentage of the target speed; the code takes the percentage of speed_limit instead.
// RULE13: speed ramps follow the acceleration and deceleration settings.
// RULE14: a nonzero timeout in ms requires a new master message within that time; zero disables it.
// RULE15: an out-of-range write or a write locked during motion is refused and the old value kept.
`timescale 1ns/1ps
module pdm_params #(
    parameter int MS_CYCLES = pdm_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic par_req,
    input wire logic par_wr,
    input wire logic [7:0] par_index,
    input wire logic [31:0] par_wdata,
    output logic par_ack,
    output logic par_err,
    output logic [31:0] par_rdata,
    input wire logic link_msg,
    input wire logic standstill,
    input wire logic manual_drive,
    input wire logic drive_start,
    input wire logic speed_settled,
    input wire logic [15:0] actual_speed,
    input wire logic [31:0] cmd_position,
    input wire logic [31:0] act_position,
    input wire logic jog_button,
    input wire logic jog_cmd,
    input wire logic brake_release_req,
    output logic following_error,
    output logic link_lost,
    output logic drive_cancel,
    output logic jog_go,
    output logic brake_go,
    output logic safe_go,
    output logic [31:0] loop_steps,
    output logic loop_enable,
    output logic loop_backward,
    output logic [15:0] jog_steps,
    output logic [15:0] brake_steps,
    output logic [31:0] safe_position,
    output logic [15:0] speed_limit,
    output logic [15:0] ccw_speed,
    output logic [15:0] cw_speed,
    output logic [15:0] ramp_up,
    output logic [15:0] ramp_down
);
    logic [31:0] approach_loop_length, link_loss_safe_position;
    logic [7:0] approach_loop_side;
    logic [15:0] comm_timeout, following_error_limit, jog_step_count, brake_release_steps, link_loss_reaction;
    logic [15:0] position_drive_max_speed, ccw_target_speed, cw_target_speed, manual_drive_max_speed;
    logic [15:0] abort_speed_percent, speed_ramp_up, speed_ramp_down;
    logic [2:0] btn_sync;
    logic btn_state, jog_cmd_d, wr_ok, wr_take;
    logic [31:0] pos_diff, pos_dist;
    logic [23:0] speed_scaled, abort_floor;
    typedef pdm_pkg::pdm_link_e pdm_link_e_t;
    pdm_link_e_t link_state;
    pdm_wd_if wd ();
    function automatic logic idx_known(input logic [7:0] idx);
        unique case (idx)
            pdm_pkg::IDX_COMM_TIMEOUT, pdm_pkg::IDX_LOOP_LEN, pdm_pkg::IDX_FOLLOW_ERR,
            pdm_pkg::IDX_LOOP_SIDE, pdm_pkg::IDX_JOG_STEPS, pdm_pkg::IDX_BRAKE_STEPS,
            pdm_pkg::IDX_LOSS_REACT, pdm_pkg::IDX_SAFE_POS, pdm_pkg::IDX_POS_SPEED,
            pdm_pkg::IDX_CCW_SPEED, pdm_pkg::IDX_CW_SPEED, pdm_pkg::IDX_JOG_SPEED,
            pdm_pkg::IDX_ABORT_PCT, pdm_pkg::IDX_RAMP_UP, pdm_pkg::IDX_RAMP_DOWN:
                idx_known = 1'b1;
            default:
                idx_known = 1'b0;
        endcase
    endfunction

    // decides whether a write value may be stored
    function automatic logic write_allowed(input logic [7:0] idx, input logic [31:0] d, input logic still);
        logic [15:0] h;
        h = d[15:0];
        write_allowed = idx_known(idx);
        unique case (idx)
            pdm_pkg::IDX_COMM_TIMEOUT:
                write_allowed = d[31:16] == 16'h0000 && h <= pdm_pkg::MAX_COMM_TIMEOUT;
            pdm_pkg::IDX_FOLLOW_ERR:
                write_allowed = d[31:16] == 16'h0000 && h >= pdm_pkg::MIN_FOLLOW_ERR
                    && h <= pdm_pkg::MAX_FOLLOW_ERR;
            // RULE4: locked during motion
            pdm_pkg::IDX_LOOP_SIDE:
                write_allowed = still && d[31:1] == 31'h0000_0000;
            pdm_pkg::IDX_JOG_STEPS:
                write_allowed = still && d[31:16] == 16'h0000 && h >= pdm_pkg::MIN_JOG_STEPS
                    && h <= pdm_pkg::MAX_JOG_STEPS;
            pdm_pkg::IDX_BRAKE_STEPS:
                write_allowed = d[31:16] == 16'h0000 && h >= pdm_pkg::MIN_BRAKE_STEPS
                    && h <= pdm_pkg::MAX_BRAKE_STEPS;
            // RULE7: code 0 is reserved
            pdm_pkg::IDX_LOSS_REACT:
                write_allowed = d[31:16] == 16'h0000
                    && (h == pdm_pkg::REACT_CANCEL || h == pdm_pkg::REACT_SAFE);
            pdm_pkg::IDX_ABORT_PCT:
                write_allowed = d[31:16] == 16'h0000 && h >= pdm_pkg::MIN_ABORT_PCT
                    && h <= pdm_pkg::MAX_ABORT_PCT;
            pdm_pkg::IDX_POS_SPEED, pdm_pkg::IDX_CCW_SPEED, pdm_pkg::IDX_CW_SPEED,
            pdm_pkg::IDX_JOG_SPEED, pdm_pkg::IDX_RAMP_UP, pdm_pkg::IDX_RAMP_DOWN:
                write_allowed = d[31:16] == 16'h0000;
            default:
                write_allowed = write_allowed;
        endcase
    endfunction

    assign wr_ok = write_allowed(par_index, par_wdata, standstill);
    // RULE15: refused write keeps value
    assign wr_take = par_req && par_wr && wr_ok;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            comm_timeout <= pdm_pkg::RST_COMM_TIMEOUT;
            approach_loop_length <= pdm_pkg::RST_LOOP_LEN;
            following_error_limit <= pdm_pkg::RST_FOLLOW_ERR;
            approach_loop_side <= pdm_pkg::RST_LOOP_SIDE;
            jog_step_count <= pdm_pkg::RST_JOG_STEPS;
            brake_release_steps <= pdm_pkg::RST_BRAKE_STEPS;
            link_loss_reaction <= pdm_pkg::RST_LOSS_REACT;
            link_loss_safe_position <= pdm_pkg::RST_SAFE_POS;
            position_drive_max_speed <= pdm_pkg::RST_POS_SPEED;
            ccw_target_speed <= pdm_pkg::RST_CCW_SPEED;
            cw_target_speed <= pdm_pkg::RST_CW_SPEED;
            manual_drive_max_speed <= pdm_pkg::RST_JOG_SPEED;
            abort_speed_percent <= pdm_pkg::RST_ABORT_PCT;
            speed_ramp_up <= pdm_pkg::RST_RAMP_UP;
            speed_ramp_down <= pdm_pkg::RST_RAMP_DOWN;
        end
        else if (wr_take)
        begin
            unique case (par_index)
                pdm_pkg::IDX_COMM_TIMEOUT: comm_timeout <= par_wdata[15:0];
                pdm_pkg::IDX_LOOP_LEN: approach_loop_length <= par_wdata;
                pdm_pkg::IDX_FOLLOW_ERR: following_error_limit <= par_wdata[15:0];
                pdm_pkg::IDX_LOOP_SIDE: approach_loop_side <= par_wdata[7:0];
                pdm_pkg::IDX_JOG_STEPS: jog_step_count <= par_wdata[15:0];
                pdm_pkg::IDX_BRAKE_STEPS: brake_release_steps <= par_wdata[15:0];
                pdm_pkg::IDX_LOSS_REACT: link_loss_reaction <= par_wdata[15:0];
                pdm_pkg::IDX_SAFE_POS: link_loss_safe_position <= par_wdata;
                pdm_pkg::IDX_POS_SPEED: position_drive_max_speed <= par_wdata[15:0];
                pdm_pkg::IDX_CCW_SPEED: ccw_target_speed <= par_wdata[15:0];
                pdm_pkg::IDX_CW_SPEED: cw_target_speed <= par_wdata[15:0];
                pdm_pkg::IDX_JOG_SPEED: manual_drive_max_speed <= par_wdata[15:0];
                pdm_pkg::IDX_ABORT_PCT: abort_speed_percent <= par_wdata[15:0];
                pdm_pkg::IDX_RAMP_UP: speed_ramp_up <= par_wdata[15:0];
                pdm_pkg::IDX_RAMP_DOWN: speed_ramp_down <= par_wdata[15:0];
                default: comm_timeout <= comm_timeout;
            endcase
        end
    end

    // answer one cycle after each request; unknown index or refused write gives an error
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            par_ack <= 1'b0;
            par_err <= 1'b0;
            par_rdata <= 32'h0000_0000;
        end
        else
        begin
            par_ack <= par_req;
            par_err <= par_req && (par_wr ? !wr_ok : !idx_known(par_index));
            par_rdata <= 32'h0000_0000;
            if (par_req && !par_wr)
            begin
                unique case (par_index)
                    pdm_pkg::IDX_COMM_TIMEOUT: par_rdata <= {16'h0000, comm_timeout};
                    pdm_pkg::IDX_LOOP_LEN: par_rdata <= approach_loop_length;
                    pdm_pkg::IDX_FOLLOW_ERR: par_rdata <= {16'h0000, following_error_limit};
                    pdm_pkg::IDX_LOOP_SIDE: par_rdata <= {24'h00_0000, approach_loop_side};
                    pdm_pkg::IDX_JOG_STEPS: par_rdata <= {16'h0000, jog_step_count};
                    pdm_pkg::IDX_BRAKE_STEPS: par_rdata <= {16'h0000, brake_release_steps};
                    pdm_pkg::IDX_LOSS_REACT: par_rdata <= {16'h0000, link_loss_reaction};
                    pdm_pkg::IDX_SAFE_POS: par_rdata <= link_loss_safe_position;
                    pdm_pkg::IDX_POS_SPEED: par_rdata <= {16'h0000, position_drive_max_speed};
                    pdm_pkg::IDX_CCW_SPEED: par_rdata <= {16'h0000, ccw_target_speed};
                    pdm_pkg::IDX_CW_SPEED: par_rdata <= {16'h0000, cw_target_speed};
                    pdm_pkg::IDX_JOG_SPEED: par_rdata <= {16'h0000, manual_drive_max_speed};
                    pdm_pkg::IDX_ABORT_PCT: par_rdata <= {16'h0000, abort_speed_percent};
                    pdm_pkg::IDX_RAMP_UP: par_rdata <= {16'h0000, speed_ramp_up};
                    pdm_pkg::IDX_RAMP_DOWN: par_rdata <= {16'h0000, speed_ramp_down};
                    default: par_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // settings handed to the motion controller, registered so they change one cycle after a write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loop_steps <= pdm_pkg::RST_LOOP_LEN;
            loop_enable <= 1'b1;
            loop_backward <= 1'b0;
            jog_steps <= pdm_pkg::RST_JOG_STEPS;
            brake_steps <= pdm_pkg::RST_BRAKE_STEPS;
            safe_position <= pdm_pkg::RST_SAFE_POS;
            speed_limit <= pdm_pkg::RST_POS_SPEED;
            ccw_speed <= pdm_pkg::RST_CCW_SPEED;
            cw_speed <= pdm_pkg::RST_CW_SPEED;
            ramp_up <= pdm_pkg::RST_RAMP_UP;
            ramp_down <= pdm_pkg::RST_RAMP_DOWN;
        end
        else
        begin
            // RULE1: zero length disables loop
            loop_steps <= approach_loop_length;
            loop_enable <= approach_loop_length != 32'h0000_0000;
            // RULE2: side selects approach
            loop_backward <= approach_loop_side[0];
            jog_steps <= jog_step_count;
            brake_steps <= brake_release_steps;
            safe_position <= link_loss_safe_position;
            // RULE10: position drive limit
            // RULE11: manual drive limit
            speed_limit <= manual_drive ? manual_drive_max_speed : position_drive_max_speed;
            ccw_speed <= ccw_target_speed;
            cw_speed <= cw_target_speed;
            // RULE13: ramp settings
            ramp_up <= speed_ramp_up;
            ramp_down <= speed_ramp_down;
        end
    end

    // RULE3: distance against limit
    assign pos_diff = cmd_position - act_position;
    assign pos_dist = pos_diff[31] ? (32'h0000_0000 - pos_diff) : pos_diff;
    // sticky until the next drive starts; a new excess in that cycle still wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            following_error <= 1'b0;
        else if (pos_dist > {16'h0000, following_error_limit})
            following_error <= 1'b1;
        else if (drive_start)
            following_error <= 1'b0;
    end

    // the first stage feeds only the second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            btn_sync <= 3'h0;
        else
            btn_sync <= {btn_sync[1:0], jog_button};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            btn_state <= 1'b0;
        else if (btn_sync[1] == btn_sync[2])
            btn_state <= btn_sync[2];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            jog_cmd_d <= 1'b0;
        else
            jog_cmd_d <= jog_cmd;
    end

    // RULE5: one jog step per press
    // RULE4: a jog move only starts from standstill, so the step count cannot change underneath it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            jog_go <= 1'b0;
        else
            jog_go <= standstill && ((btn_sync[1] == btn_sync[2] && btn_sync[2] && !btn_state)
                || (jog_cmd && !jog_cmd_d));
    end

    // RULE6: brake release move
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            brake_go <= 1'b0;
        else
            brake_go <= brake_release_req;
    end

    assign wd.timeout_ms = comm_timeout;
    // RULE14: any request is a message
    assign wd.msg = link_msg || par_req;
    pdm_watchdog #(.MS_CYCLES(MS_CYCLES)) u_watchdog (
        .clk(clk),
        .nrst(nrst),
        .wd(wd)
    );

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            link_state <= pdm_pkg::PDM_LINK_IDLE;
        else
        begin
            unique case (link_state)
                pdm_pkg::PDM_LINK_IDLE:
                    if (comm_timeout != 16'h0000)
                        link_state <= pdm_pkg::PDM_LINK_WATCH;
                pdm_pkg::PDM_LINK_WATCH:
                    if (comm_timeout == 16'h0000)
                        link_state <= pdm_pkg::PDM_LINK_IDLE;
                    else if (wd.lost)
                        link_state <= pdm_pkg::PDM_LINK_LOST;
                pdm_pkg::PDM_LINK_LOST:
                    if (!wd.lost)
                        link_state <= pdm_pkg::PDM_LINK_IDLE;
                default:
                    link_state <= pdm_pkg::PDM_LINK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            link_lost <= 1'b0;
        else
            link_lost <= link_state == pdm_pkg::PDM_LINK_LOST;
    end

    // RULE9: drive to safe position
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            safe_go <= 1'b0;
        else
            safe_go <= link_state == pdm_pkg::PDM_LINK_WATCH && wd.lost
                && link_loss_reaction == pdm_pkg::REACT_SAFE;
    end

    // RULE12: speed under abort floor
    assign speed_scaled = 24'(actual_speed) * 24'(pdm_pkg::PCT_FULL);
    assign abort_floor = 24'(abort_speed_percent[7:0]) * 24'(speed_limit);

    // cancel on link loss with the cancel reaction or on a stall; the stall is only checked once the start-up ramp is over
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            drive_cancel <= 1'b0;
        else
            // RULE7: cancel reaction
            drive_cancel <= (link_state == pdm_pkg::PDM_LINK_WATCH && wd.lost
                && link_loss_reaction == pdm_pkg::REACT_CANCEL)
                || (!standstill && speed_settled && speed_scaled < abort_floor);
    end
endmodule

/* logic/pdm_pkg.sv */
// constants and types of the positioning drive motion parameter block
package pdm_pkg;
    localparam logic [7:0] IDX_COMM_TIMEOUT = 8'h76;
    localparam logic [7:0] IDX_LOOP_LEN = 8'h84;
    localparam logic [7:0] IDX_FOLLOW_ERR = 8'h85;
    localparam logic [7:0] IDX_LOOP_SIDE = 8'h86;
    localparam logic [7:0] IDX_JOG_STEPS = 8'h87;
    localparam logic [7:0] IDX_BRAKE_STEPS = 8'h88;
    localparam logic [7:0] IDX_LOSS_REACT = 8'h89;
    localparam logic [7:0] IDX_SAFE_POS = 8'h8A;
    localparam logic [7:0] IDX_POS_SPEED = 8'h8E;
    localparam logic [7:0] IDX_CCW_SPEED = 8'h8F;
    localparam logic [7:0] IDX_CW_SPEED = 8'h90;
    localparam logic [7:0] IDX_JOG_SPEED = 8'h91;
    localparam logic [7:0] IDX_ABORT_PCT = 8'h92;
    localparam logic [7:0] IDX_RAMP_UP = 8'h93;
    localparam logic [7:0] IDX_RAMP_DOWN = 8'h94;

    localparam logic [15:0] RST_COMM_TIMEOUT = 16'h0000;
    localparam logic [31:0] RST_LOOP_LEN = 32'h0000_00FA;
    localparam logic [15:0] RST_FOLLOW_ERR = 16'h0028;
    localparam logic [7:0] RST_LOOP_SIDE = 8'h00;
    localparam logic [15:0] RST_JOG_STEPS = 16'h0001;
    localparam logic [15:0] RST_BRAKE_STEPS = 16'h000A;
    localparam logic [15:0] RST_LOSS_REACT = 16'h0001;
    localparam logic [31:0] RST_SAFE_POS = 32'h0000_0000;
    localparam logic [15:0] RST_POS_SPEED = 16'h0064;
    localparam logic [15:0] RST_CCW_SPEED = 16'h0064;
    localparam logic [15:0] RST_CW_SPEED = 16'h0064;
    localparam logic [15:0] RST_JOG_SPEED = 16'h0032;
    localparam logic [15:0] RST_ABORT_PCT = 16'h001E;
    localparam logic [15:0] RST_RAMP_UP = 16'h0064;
    localparam logic [15:0] RST_RAMP_DOWN = 16'h0064;

    localparam logic [15:0] MAX_COMM_TIMEOUT = 16'h2710;
    localparam logic [15:0] MIN_FOLLOW_ERR = 16'h0014;
    localparam logic [15:0] MAX_FOLLOW_ERR = 16'h03E8;
    localparam logic [15:0] MIN_JOG_STEPS = 16'h0001;
    localparam logic [15:0] MAX_JOG_STEPS = 16'h0064;
    localparam logic [15:0] MIN_BRAKE_STEPS = 16'h0001;
    localparam logic [15:0] MAX_BRAKE_STEPS = 16'h0032;
    localparam logic [15:0] MIN_ABORT_PCT = 16'h001E;
    localparam logic [15:0] MAX_ABORT_PCT = 16'h005A;
    localparam logic [15:0] REACT_CANCEL = 16'h0001;
    localparam logic [15:0] REACT_SAFE = 16'h0002;
    localparam logic [7:0] PCT_FULL = 8'h64;

    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        PDM_LINK_IDLE = 2'b00,
        PDM_LINK_WATCH = 2'b01,
        PDM_LINK_LOST = 2'b11
    } pdm_link_e;
endpackage

/* logic/pdm_wd_if.sv */
// link watchdog signals between the parameter block and its timer
`timescale 1ns/1ps
interface pdm_wd_if;
    logic [15:0] timeout_ms;
    logic msg;
    logic lost;
    modport ctl (output timeout_ms, output msg, input lost);
    modport tmr (input timeout_ms, input msg, output lost);
endinterface

/* logic/pdm_watchdog.sv */
// millisecond link watchdog restarted by every master message
`timescale 1ns/1ps
module pdm_watchdog #(
    parameter int MS_CYCLES = pdm_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    pdm_wd_if.tmr wd
);
    logic [31:0] pre_cnt;
    logic [15:0] ms_cnt;
    logic ms_tick;

    assign ms_tick = (pre_cnt == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pre_cnt <= 32'h0000_0000;
        else if (wd.msg || ms_tick || wd.timeout_ms == 16'h0000)
            pre_cnt <= 32'h0000_0000;
        else
            pre_cnt <= pre_cnt + 32'h0000_0001;
    end

    // RULE14: message restarts window
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ms_cnt <= 16'h0000;
        else if (wd.msg || wd.timeout_ms == 16'h0000)
            ms_cnt <= 16'h0000;
        else if (ms_tick && ms_cnt != 16'hFFFF)
            ms_cnt <= ms_cnt + 16'h0001;
    end

    // RULE8: disabled at zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wd.lost <= 1'b0;
        else if (wd.msg || wd.timeout_ms == 16'h0000)
            wd.lost <= 1'b0;
        else if (ms_cnt >= wd.timeout_ms)
            wd.lost <= 1'b1;
    end
endmodule

/* tb/pdm_params_asserts.sv */
// port-level checks of the motion parameter block
`timescale 1ns/1ps
module pdm_params_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic par_req,
    input wire logic par_ack,
    input wire logic par_err,
    input wire logic [31:0] par_rdata,
    input wire logic standstill,
    input wire logic jog_cmd,
    input wire logic jog_go,
    input wire logic link_msg,
    input wire logic link_lost,
    input wire logic safe_go,
    input wire logic [31:0] loop_steps,
    input wire logic loop_enable,
    input wire logic [15:0] jog_steps
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence req_s;
        par_req;
    endsequence
    sequence jog_rise_s;
        standstill && $rose(jog_cmd);
    endsequence
    ack_after_req_a: assert property (req_s |=> par_ack)
        else $error("request without acknowledge");
    ack_cause_a: assert property (par_ack |-> $past(par_req))
        else $error("acknowledge without request");
    err_with_ack_a: assert property (par_err |-> par_ack)
        else $error("error flag outside acknowledge");
    rdata_idle_a: assert property (!par_ack |-> par_rdata == 32'h0)
        else $error("read data outside acknowledge");
    loop_off_a: assert property (loop_enable == (loop_steps != 32'h0))
        else $error("loop enable does not follow loop length");
    jog_lock_a: assert property ($changed(jog_steps) |-> $past(standstill, 2))
        else $error("jog step count changed during motion");
    jog_move_a: assert property (jog_rise_s |=> jog_go)
        else $error("jog command gave no jog move");
    safe_lost_a: assert property (safe_go |=> link_lost)
        else $error("safe drive without link loss");
    msg_clears_a: assert property (link_msg |-> ##[1:3] !link_lost)
        else $error("message did not clear link loss");
endmodule

/* tb/pdm_master.sv */
// master model issuing one parameter request per call
`timescale 1ns/1ps
module pdm_master (
    input wire logic clk,
    output logic par_req,
    output logic par_wr,
    output logic [7:0] par_index,
    output logic [31:0] par_wdata,
    input wire logic par_ack,
    input wire logic par_err,
    input wire logic [31:0] par_rdata
);
    initial
    begin
        par_req = 1'h0;
        par_wr = 1'h0;
        par_index = 8'h00;
        par_wdata = 32'h0;
    end
    // each request also keeps the link alive
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                        output logic [1:0] ae, output logic [31:0] q);
        @(negedge clk);
        par_req = 1'h1;
        par_wr = wr;
        par_index = idx;
        par_wdata = d;
        @(negedge clk);
        // the answer stands for one cycle only, so take it before moving on
        ae = {par_ack, par_err};
        q = par_rdata;
        par_req = 1'h0;
        // stale data would hide a design that samples late
        par_wdata = ~d;
        par_index = ~idx;
    endtask
endmodule

/* tb/pdm_params_bench.sv */
// self-checking bench of the motion parameter block
`timescale 1ns/1ps
module pdm_params_bench;
    logic clk, nrst, par_req, par_wr, par_ack, par_err, link_msg, standstill, manual_drive, drive_start;
    logic speed_settled, jog_button, jog_cmd, brake_release_req, following_error, link_lost, drive_cancel;
    logic jog_go, brake_go, safe_go, loop_enable, loop_backward;
    logic [7:0] par_index;
    logic [15:0] actual_speed, jog_steps, brake_steps, speed_limit, ccw_speed, cw_speed, ramp_up, ramp_down;
    logic [31:0] par_wdata, par_rdata, cmd_position, act_position, loop_steps, safe_position;
    int bad_count = 0;
    int cmp_count = 0;
    pdm_params #(.MS_CYCLES(10)) DUT (.*);
    pdm_master u_mst (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // read compares data, ae is the expected acknowledge and error pair
    task automatic rw(input logic wr, input logic [7:0] i, input logic [31:0] d, input logic [1:0] ae);
        logic [1:0] r;
        logic [31:0] q;
        u_mst.xfer(wr, i, d, r, q);
        chk(r, ae);
        if (!wr)
            chk(q, d);
    endtask
    task automatic wait_for(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'h1; i++)
            @(negedge clk);
        chk(s, 1'h1);
    endtask
    task automatic t_reset;
        chk(loop_steps, 32'h0000_00FA);
        chk(loop_backward, 1'h0);
        chk(jog_steps, 16'h0001);
        chk(speed_limit, 16'h0064);
        chk({ccw_speed, cw_speed}, 32'h0064_0064);
        chk({ramp_up, ramp_down}, 32'h0064_0064);
        rw(0, pdm_pkg::IDX_LOOP_LEN, 32'h0000_00FA, 2'h2);
        rw(0, 8'h8B, 32'h0, 2'h3);
        $display("reset test done");
    endtask
    task automatic t_jog;
        standstill = 1'h0;
        rw(1, pdm_pkg::IDX_JOG_STEPS, 32'h5, 2'h3);
        standstill = 1'h1;
        rw(1, pdm_pkg::IDX_JOG_STEPS, 32'h65, 2'h3);
        rw(1, pdm_pkg::IDX_JOG_STEPS, 32'h64, 2'h2);
        repeat (2) @(negedge clk);
        chk(jog_steps, 16'h0064);
        jog_cmd = 1'h1;
        wait_for(jog_go, 4);
        jog_cmd = 1'h0;
        @(negedge clk);
        jog_button = 1'h1;
        wait_for(jog_go, 6);
        jog_button = 1'h0;
        brake_release_req = 1'h1;
        @(negedge clk);
        brake_release_req = 1'h0;
        wait_for(brake_go, 4);
        chk(brake_steps, 16'h000A);
        $display("jog test done");
    endtask
    task automatic t_loop;
        rw(1, pdm_pkg::IDX_LOOP_LEN, 32'h0, 2'h2);
        rw(1, pdm_pkg::IDX_LOOP_SIDE, 32'h1, 2'h2);
        rw(1, pdm_pkg::IDX_LOOP_SIDE, 32'h2, 2'h3);
        repeat (2) @(negedge clk);
        chk(loop_enable, 1'h0);
        chk(loop_backward, 1'h1);
        // difference equal to the limit must not flag
        cmd_position = 32'h28;
        repeat (3) @(negedge clk);
        chk(following_error, 1'h0);
        cmd_position = 32'h29;
        wait_for(following_error, 3);
        drive_start = 1'h1;
        @(negedge clk);
        chk(following_error, 1'h1);
        cmd_position = 32'h0;
        @(negedge clk);
        drive_start = 1'h0;
        chk(following_error, 1'h0);
        $display("loop test done");
    endtask
    task automatic t_speed;
        manual_drive = 1'h1;
        standstill = 1'h0;
        speed_settled = 1'h1;
        actual_speed = 16'h000F;
        repeat (2) @(negedge clk);
        chk(speed_limit, 16'h0032);
        chk(drive_cancel, 1'h0);
        actual_speed = 16'h000E;
        wait_for(drive_cancel, 3);
        {manual_drive, standstill, speed_settled} = 3'h2;
        $display("speed test done");
    endtask
    task automatic t_link;
        rw(1, pdm_pkg::IDX_LOSS_REACT, 32'h0, 2'h3);
        rw(1, pdm_pkg::IDX_LOSS_REACT, 32'h2, 2'h2);
        rw(1, pdm_pkg::IDX_SAFE_POS, 32'hFFFF_FF9C, 2'h2);
        repeat (40) @(negedge clk);
        chk(link_lost, 1'h0);
        rw(1, pdm_pkg::IDX_COMM_TIMEOUT, 32'h1, 2'h2);
        wait_for(safe_go, 20);
        chk(safe_position, 32'hFFFF_FF9C);
        wait_for(link_lost, 3);
        link_msg = 1'h1;
        @(negedge clk);
        link_msg = 1'h0;
        repeat (3) @(negedge clk);
        chk(link_lost, 1'h0);
        rw(1, pdm_pkg::IDX_LOSS_REACT, 32'h1, 2'h2);
        wait_for(drive_cancel, 20);
        $display("link test done");
    endtask
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        {nrst, link_msg, manual_drive, drive_start, speed_settled, jog_button, jog_cmd} = 7'h00;
        {brake_release_req, actual_speed, cmd_position, act_position} = 81'h0;
        standstill = 1'h1;
        nrst = 1'h0;
        repeat (8) @(negedge clk);
        nrst = 1'h1;
        t_reset;
        t_jog;
        t_loop;
        t_speed;
        t_link;
        end_sim;
    end
    initial
    begin
        #100000;
        bad_count++;
        end_sim;
    end
endmodule
bind pdm_params pdm_params_asserts u_chk (.*);
